/* rtl/dab_regs.sv */
// AXI4-Lite register bank driving the dual amplifier block controls
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "dab_map.svh"

// Notes on behaviour
// - Block enable bit 31 powers whole block down at 0, up at 1.
// - Bit 11 of each resource register turns that amplifier's charge pump on.
// - Bits 1:0 pick off, low, medium or high power per amplifier.
// - Bit 2 selects 1X internal driver at 0, 10X external at 1.
// - 1X and 10X drivers are never on together.
// - 1X output goes to ADC buses, 10X to the external pin.
// - Switch bit 21 permits opposite routing of drivers, unguaranteed.
// - Output stage is at most one of 1X, 10X or comparator; none while the amplifier is off.
// - Compensation bits 1:0 select none, minimum, medium or maximum capacitance.
// - Each switch register bit closes its switch at 1, opens at 0.
// - Writing 1 to a switch-clear bit opens that switch; zeros ignored.
// - ADC bus switches need both ADC channel config and this block.
// - Control logic keeps working in deep sleep.
module dab_regs
   import dab_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [2:0] adc_bus_request,
   output logic block_enabled,
   output dab_amp_ctrl_type amp0_ctrl,
   output dab_amp_ctrl_type amp1_ctrl,
   output logic [2:0] adc_bus_switch
);
   // Configuration registers
   logic [31:0] block_control, next_block_control;
   logic [31:0] amp_res [2];
   logic [31:0] next_amp_res [2];
   logic [31:0] amp_comp [2];
   logic [31:0] next_amp_comp [2];
   logic [31:0] amp_sw [2];
   logic [31:0] next_amp_sw [2];

   // Bus state
   logic aw_held, next_aw_held, w_held, next_w_held;
   dab_wreq_type wreq, next_wreq;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;

   // Outputs and ADC request synchronizer
   logic next_block_enabled;
   dab_amp_ctrl_type next_amp_ctrl [2];
   logic [2:0] next_adc_bus_switch;
   logic [2:0] adc_req_meta, adc_req_sync;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res & mask;
   endfunction

   // Write channel: address and data taken in either order, response after both
   always_comb begin
      logic do_write;
      logic hit;
      do_write = 1'b0;
      hit = 1'b1;
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_wreq = wreq;
      next_awready = awready;
      next_wready = wready;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_block_control = block_control;
      next_amp_res = amp_res;
      next_amp_comp = amp_comp;
      next_amp_sw = amp_sw;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_awready = 1'b0;
         next_wreq.addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_wready = 1'b0;
         next_wreq.data = wdata;
         next_wreq.strb = wstrb;
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
         next_awready = 1'b1;
         next_wready = 1'b1;
      end
      if (aw_held && w_held && !bvalid) begin
         do_write = 1'b1;
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
      end
      // Masks keep unimplemented bits at zero so they always read back as 0
      if (do_write) begin
         unique case (wreq.addr)
            `DAB_OFF_BLOCK_CONTROL:
               next_block_control = merge(block_control, wreq.data, wreq.strb, 32'h8000_0000);
            `DAB_OFF_AMP0_RES:
               next_amp_res[0] = merge(amp_res[0], wreq.data, wreq.strb, `DAB_RES_MASK);
            `DAB_OFF_AMP1_RES:
               next_amp_res[1] = merge(amp_res[1], wreq.data, wreq.strb, `DAB_RES_MASK);
            `DAB_OFF_AMP0_COMP:
               next_amp_comp[0] = merge(amp_comp[0], wreq.data, wreq.strb, `DAB_COMP_MASK);
            `DAB_OFF_AMP1_COMP:
               next_amp_comp[1] = merge(amp_comp[1], wreq.data, wreq.strb, `DAB_COMP_MASK);
            `DAB_OFF_AMP0_SW:
               next_amp_sw[0] = merge(amp_sw[0], wreq.data, wreq.strb, `DAB_SW_MASK);
            `DAB_OFF_AMP1_SW:
               next_amp_sw[1] = merge(amp_sw[1], wreq.data, wreq.strb, `DAB_SW_MASK);
            // Clear strobes only touch ones; zeros leave the closures alone
            `DAB_OFF_AMP0_SW_CLR:
               next_amp_sw[0] = amp_sw[0] & ~merge(32'h0, wreq.data, wreq.strb, 32'hffff_ffff);
            `DAB_OFF_AMP1_SW_CLR:
               next_amp_sw[1] = amp_sw[1] & ~merge(32'h0, wreq.data, wreq.strb, 32'hffff_ffff);
            // Status is read only; a write is accepted and dropped
            `DAB_OFF_STATUS: hit = 1'b1;
            default: hit = 1'b0;
         endcase
         next_bresp = hit ? `DAB_RESP_OKAY : `DAB_RESP_SLVERR;
      end
   end

   // Read channel
   always_comb begin
      next_arready = arready;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      if (arvalid && arready) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = `DAB_RESP_OKAY;
         unique case (araddr)
            `DAB_OFF_BLOCK_CONTROL: next_rdata = block_control;
            `DAB_OFF_AMP0_RES: next_rdata = amp_res[0];
            `DAB_OFF_AMP1_RES: next_rdata = amp_res[1];
            `DAB_OFF_AMP0_COMP: next_rdata = amp_comp[0];
            `DAB_OFF_AMP1_COMP: next_rdata = amp_comp[1];
            `DAB_OFF_AMP0_SW: next_rdata = amp_sw[0];
            `DAB_OFF_AMP1_SW: next_rdata = amp_sw[1];
            `DAB_OFF_AMP0_SW_CLR: next_rdata = 32'h0000_0000;
            `DAB_OFF_AMP1_SW_CLR: next_rdata = 32'h0000_0000;
            `DAB_OFF_STATUS: next_rdata = {29'h0, adc_bus_switch};
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = `DAB_RESP_SLVERR;
            end
         endcase
      end
   end

   // One decoder per amplifier; block enable gates every analog output except route_opposite and adc_switch_enable
   for (genvar g = 0; g < 2; g++) begin : gen_amp
      logic on;
      logic cmp;
      dab_amp_ctrl_type next_ctrl;
      always_comb begin
         on = block_control[`DAB_BIT_ENABLE] && (amp_res[g][1:0] != 2'b00);
         cmp = amp_res[g][`DAB_BIT_COMP_MODE];
         next_ctrl = '0;
         next_ctrl.power_level = on ? dab_power_type'(amp_res[g][1:0]) : dab_pwr_off;
         next_ctrl.charge_pump_on = block_control[`DAB_BIT_ENABLE] && amp_res[g][`DAB_BIT_PUMP];
         // Comparator mode shuts both drivers so only one output stage is ever live
         next_ctrl.comparator_on = on && cmp;
         next_ctrl.drive_1x_on = on && !cmp && !amp_res[g][`DAB_BIT_DRIVER];
         next_ctrl.drive_10x_on = on && !cmp && amp_res[g][`DAB_BIT_DRIVER];
         // Opposite routing is allowed but its analog performance is not promised
         next_ctrl.route_opposite = amp_sw[g][`DAB_BIT_OPPOSITE];
         // Compensation caps are cut in comparator mode
         next_ctrl.compensation_level = (on && !cmp) ? amp_comp[g][1:0] : 2'b00;
         next_ctrl.switch_closures = block_control[`DAB_BIT_ENABLE] ? amp_sw[g] : 32'h0;
         next_ctrl.adc_switch_enable = amp_sw[g][`DAB_BIT_ADC_SW_EN];
      end
   end

   // Bus 0 from amp 0, buses 1 and 2 from amp 1
   localparam int adc_sw_source [3] = '{0, 1, 1};
   for (genvar s = 0; s < 3; s++) begin : gen_adc
      logic sw_on;
      // ADC side must also ask; neither side alone closes a bus switch
      always_comb begin
         sw_on = block_control[`DAB_BIT_ENABLE] && amp_sw[adc_sw_source[s]][`DAB_BIT_ADC_SW_EN]
                 && adc_req_sync[s];
      end
   end

   // Gathers the per-amplifier and per-switch decodes for the output flops
   always_comb begin
      next_block_enabled = block_control[`DAB_BIT_ENABLE];
      next_amp_ctrl[0] = gen_amp[0].next_ctrl;
      next_amp_ctrl[1] = gen_amp[1].next_ctrl;
      next_adc_bus_switch = {gen_adc[2].sw_on, gen_adc[1].sw_on, gen_adc[0].sw_on};
   end

   // Only mclk and clk_en gate state, so deep sleep keeps the bank alive if mclk runs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         block_control <= `DAB_RESET_VALUE;
         amp_res <= '{default: `DAB_RESET_VALUE};
         amp_comp <= '{default: `DAB_RESET_VALUE};
         amp_sw <= '{default: `DAB_RESET_VALUE};
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wreq <= '0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= 2'b00;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
         block_enabled <= 1'b0;
         amp0_ctrl <= '0;
         amp1_ctrl <= '0;
         adc_bus_switch <= 3'h0;
         adc_req_meta <= 3'h0;
         adc_req_sync <= 3'h0;
      end else if (clk_en) begin
         block_control <= next_block_control;
         amp_res <= next_amp_res;
         amp_comp <= next_amp_comp;
         amp_sw <= next_amp_sw;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wreq <= next_wreq;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         block_enabled <= next_block_enabled;
         amp0_ctrl <= next_amp_ctrl[0];
         amp1_ctrl <= next_amp_ctrl[1];
         adc_bus_switch <= next_adc_bus_switch;
         adc_req_meta <= adc_bus_request;
         adc_req_sync <= adc_req_meta;
      end
   end
endmodule

/* rtl/dab_map.svh */
// Register offsets, field positions and reset values of the dual amplifier block
`ifndef DAB_MAP_SVH
`define DAB_MAP_SVH
`define DAB_OFF_BLOCK_CONTROL 8'h00
`define DAB_OFF_AMP0_RES 8'h04
`define DAB_OFF_AMP1_RES 8'h08
`define DAB_OFF_AMP0_COMP 8'h0c
`define DAB_OFF_AMP1_COMP 8'h10
`define DAB_OFF_AMP0_SW 8'h14
`define DAB_OFF_AMP1_SW 8'h18
`define DAB_OFF_AMP0_SW_CLR 8'h1c
`define DAB_OFF_AMP1_SW_CLR 8'h20
`define DAB_OFF_STATUS 8'h24
`define DAB_BIT_ENABLE 31
`define DAB_BIT_PUMP 11
`define DAB_BIT_DRIVER 2
`define DAB_BIT_COMP_MODE 4
`define DAB_BIT_OPPOSITE 21
`define DAB_BIT_ADC_SW_EN 18
`define DAB_RES_MASK 32'h0000_0877
`define DAB_COMP_MASK 32'h0000_0003
`define DAB_SW_MASK 32'h0024_411f
`define DAB_RESET_VALUE 32'h0000_0000
`define DAB_RESP_OKAY 2'b00
`define DAB_RESP_SLVERR 2'b10
`endif

/* rtl/dab_pkg.sv */
// Types shared by the dual amplifier block
package dab_pkg;
   typedef enum logic [1:0] {
      dab_pwr_off,
      dab_pwr_low,
      dab_pwr_medium,
      dab_pwr_high
   } dab_power_type;

   typedef struct packed {
      dab_power_type power_level;
      logic charge_pump_on;
      logic drive_1x_on;
      logic drive_10x_on;
      logic comparator_on;
      logic route_opposite;
      logic [1:0] compensation_level;
      logic [31:0] switch_closures;
      logic adc_switch_enable;
   } dab_amp_ctrl_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } dab_wreq_type;
endpackage

/* tb/dab_regs_assertions.sv */
// Bus and control checks for the dual amplifier register bank
`timescale 1ns/1ns
module dab_regs_assertions
   import dab_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic block_enabled,
   input dab_amp_ctrl_type amp0_ctrl,
   input dab_amp_ctrl_type amp1_ctrl,
   input wire logic [2:0] adc_bus_switch
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_disabled;
      !block_enabled && $past(!block_enabled);
   endsequence
   a_wr_answer: assert property (s_wr_taken |-> ##2 bvalid) else $error("write answer late");
   a_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
   a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
   a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped");
   a_wr_busy: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
   a_drv_excl: assert property ($onehot0({amp0_ctrl.drive_1x_on, amp0_ctrl.drive_10x_on, amp0_ctrl.comparator_on})
      && $onehot0({amp1_ctrl.drive_1x_on, amp1_ctrl.drive_10x_on, amp1_ctrl.comparator_on})) else $error("two stages on");
   a_off_dis: assert property (s_disabled |-> amp0_ctrl.power_level == dab_pwr_off && !amp0_ctrl.charge_pump_on
      && amp1_ctrl.power_level == dab_pwr_off && !amp1_ctrl.charge_pump_on) else $error("amp on while disabled");
   a_adc_gate: assert property (adc_bus_switch != 3'h0 |-> block_enabled) else $error("adc switch while disabled");
endmodule

bind dab_regs dab_regs_assertions u_chk (.mclk(mclk), .arst_n(arst_n), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .block_enabled(block_enabled),
   .amp0_ctrl(amp0_ctrl), .amp1_ctrl(amp1_ctrl), .adc_bus_switch(adc_bus_switch));

/* tb/dab_regs_tb.sv */
// Self-checking bench for the dual amplifier register bank
`timescale 1ns/1ns
module dab_regs_tb;
   import dab_pkg::*;
   logic mclk = 0, arst_n = 0, clk_en = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic [2:0] adc_bus_request = 0, adc_bus_switch;
   logic awready, wready, bvalid, arready, rvalid, block_enabled;
   logic [1:0] bresp, rresp;
   dab_amp_ctrl_type amp0_ctrl, amp1_ctrl;
   int failures = 0, num_checks = 0, cycles = 0;
   dab_regs u_dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .adc_bus_request(adc_bus_request),
      .block_enabled(block_enabled), .amp0_ctrl(amp0_ctrl), .amp1_ctrl(amp1_ctrl), .adc_bus_switch(adc_bus_switch));
   always #5 mclk = ~mclk;
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         finish_test();
      end
   end
   task finish_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Handshakes sampled at the falling edge, where they equal what the next rising edge sees
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ah, wh, bh, done;
      logic [1:0] rsp;
      done = 0;
      @(posedge mclk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!done) begin
         @(negedge mclk);
         ah = awvalid && awready; wh = wvalid && wready; bh = bvalid; rsp = bresp;
         @(posedge mclk);
         if (ah) awvalid <= 0;
         if (wh) wvalid <= 0;
         if (bh) begin
            bready <= 0;
            done = 1;
         end
      end
      chk("bresp", {30'h0, er}, {30'h0, rsp});
   endtask
   task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ah, done;
      done = 0;
      @(posedge mclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      while (!done) begin
         @(negedge mclk);
         ah = arvalid && arready;
         if (rvalid) begin
            chk("rdata", ed, rdata);
            chk("rresp", {30'h0, er}, {30'h0, rresp});
            done = 1;
         end
         @(posedge mclk);
         if (ah) arvalid <= 0;
         if (done) rready <= 0;
      end
   endtask
   task settle();
      repeat (4) @(negedge mclk);
   endtask
   task t_reset();
      for (int i = 0; i <= 8'h24; i += 4) rd(i[7:0], 32'h0, `DAB_RESP_OKAY);
      chk("enabled", 0, block_enabled);
      chk("amp0", 0, amp0_ctrl[31:0]);
      $display("reset test done");
   endtask
   task t_amp();
      wr(8'h00, 32'hffff_ffff, 4'hf, `DAB_RESP_OKAY);
      rd(8'h00, 32'h8000_0000, `DAB_RESP_OKAY);
      for (int m = 0; m < 8; m++) begin
         wr(8'h04, 32'h800 | m, 4'hf, `DAB_RESP_OKAY);
         settle();
         chk("power", m % 4, amp0_ctrl.power_level);
         chk("pump", 1, amp0_ctrl.charge_pump_on);
         chk("drv1x", (m % 4 != 0) && m < 4, amp0_ctrl.drive_1x_on);
         chk("drv10x", (m % 4 != 0) && m >= 4, amp0_ctrl.drive_10x_on);
      end
      wr(8'h0c, 32'h3, 4'hf, `DAB_RESP_OKAY);
      wr(8'h04, 32'h13, 4'hf, `DAB_RESP_OKAY);
      settle();
      chk("comp_on", 1, amp0_ctrl.comparator_on);
      chk("drv_off", 0, {amp0_ctrl.drive_1x_on, amp0_ctrl.drive_10x_on, amp0_ctrl.compensation_level});
      wr(8'h08, 32'h1, 4'hf, `DAB_RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
         wr(8'h10, 32'hffff_fff0 | c, 4'hf, `DAB_RESP_OKAY);
         rd(8'h10, c, `DAB_RESP_OKAY);
         settle();
         chk("comp", c, amp1_ctrl.compensation_level);
      end
      $display("amplifier test done");
   endtask
   task t_switch();
      wr(8'h14, 32'hffff_ffff, 4'hf, `DAB_RESP_OKAY);
      rd(8'h14, `DAB_SW_MASK, `DAB_RESP_OKAY);
      settle();
      chk("closures", `DAB_SW_MASK, amp0_ctrl.switch_closures);
      chk("opposite", 1, amp0_ctrl.route_opposite);
      wr(8'h1c, 32'h0004_0005, 4'h1, `DAB_RESP_OKAY);
      rd(8'h14, 32'h0024_411a, `DAB_RESP_OKAY);
      rd(8'h1c, 32'h0, `DAB_RESP_OKAY);
      adc_bus_request <= 3'h7;
      wr(8'h18, 32'h0004_0000, 4'hf, `DAB_RESP_OKAY);
      settle();
      chk("adc_sw", 3'h7, adc_bus_switch);
      chk("adc_en", 1, amp1_ctrl.adc_switch_enable);
      rd(8'h24, 32'h7, `DAB_RESP_OKAY);
      wr(8'h1c, 32'h0004_0000, 4'hf, `DAB_RESP_OKAY);
      settle();
      chk("adc_sw", 3'h6, adc_bus_switch);
      @(posedge mclk);
      clk_en <= 0;
      adc_bus_request <= 3'h0;
      settle();
      chk("frozen", 3'h6, adc_bus_switch);
      @(posedge mclk);
      clk_en <= 1;
      settle();
      chk("adc_sw", 3'h0, adc_bus_switch);
      $display("switch test done");
   endtask
   task t_misc();
      wr(8'h40, 32'h1, 4'hf, `DAB_RESP_SLVERR);
      rd(8'h40, 32'h0, `DAB_RESP_SLVERR);
      wr(8'h08, 32'h801, 4'hf, `DAB_RESP_OKAY);
      settle();
      chk("pump_on", 1, amp1_ctrl.charge_pump_on);
      wr(8'h00, 32'h0, 4'hf, `DAB_RESP_OKAY);
      settle();
      chk("enabled", 0, block_enabled);
      chk("pump_off", 0, amp1_ctrl.charge_pump_on);
      chk("pwr_off", 0, amp1_ctrl.power_level);
      rd(8'h08, 32'h801, `DAB_RESP_OKAY);
      $display("error and disable test done");
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      arst_n <= 1;
      t_reset();
      t_amp();
      t_switch();
      t_misc();
      finish_test();
   end
endmodule
